// ==== hdl/cke_power_ctrl.sv ====
// CKE driven power-state controller of the memory device
//
// Functional notes
// R1: controller holds CKE at least three edges after each change.
// R2: after power-down exit controller waits tXP before non-READ commands.
// R3: fast exit: READ allowed tXARD after active power-down exit.
// R4: slow exit: READ allowed only after longer tXARDS.
// R5: transition from previous CKE, current CKE, command and state.
// R6: CKE falling with NOP/DESELECT enters active or precharge power-down.
// R7: self refresh only from idle via REFRESH with CKE falling.
// R8: after self refresh exit only NOP/DESELECT for tXSNR; READ after 200.
// R9: no power-down entry while read, write, mode or precharge runs.
// R10: unlisted state, CKE and command combinations are illegal.
// R11: ODT does not steer states; termination off in self refresh.
// R12: no refresh in power-down; controller limits power-down length.
// R13: in power-down inputs other than CKE are ignored; ODT still drives odt_active_o in both power-down states.
// R14: entry earliest the clock after burst completion.
// R15: after write auto precharge, entry one clock after recovery.
// R16: precharge power-down may follow REFRESH by one clock.
// R17: active power-down may follow ACTIVE by one clock.
// R18: precharge power-down may follow PRECHARGE by one clock.
// R19: LOAD MODE needs idle banks; wait tMRD before power-down.
// R20: clock change only in precharge power-down, two clocks after entry.
// R21: during clock change ODT and CKE stay low.
// R22: after such exit DLL reset, ODT off for 200 cycles.
// R23: power-down disables buffers; DLL frozen in precharge power-down.
// R24: explicit state updated only at rising clock edges.
`default_nettype none
module cke_power_ctrl
  import pwr_state_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        cke_i,
  input  wire logic [3:0]  cmd_i,
  input  wire logic        any_bank_open_i,
  input  wire logic        odt_i,
  input  wire logic [3:0]  reg_addr_i,
  input  wire logic [31:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic [31:0]      reg_rdata_o,
  output logic [1:0]       pwr_state_o,
  output logic             buffers_en_o,
  output logic             dll_frozen_o,
  output logic             odt_active_o,
  output logic             read_ok_o,
  output logic             cmd_ok_o
);
  // ---------------------------------------------------------------
  // pin synchronisation
  // ---------------------------------------------------------------
  mem_in_type pin_raw;
  mem_in_type pin_s;
  logic       odt_s;

  assign pin_raw = '{cke: cke_i, cmd: cmd_i, any_bank_open: any_bank_open_i};

  sync2 #(.WIDTH(7)) u_sync (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .d_i        ({pin_raw, odt_i}),
    .q_o        ({pin_s, odt_s})
  );

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    pwr_state_type state;
    logic          cke_prev;
    logic [1:0]    cke_run;
    logic [1:0]    ctrl;
    err_type       err;
    logic [15:0]   pd_limit;
    logic [15:0]   pd_cnt;
    logic [CNT_W-1:0] read_cnt;
    logic [31:0]   rdata;
    logic          buffers_en;
    logic          dll_frozen;
    logic          odt_active;
    logic          read_ok;
  } ctl_state_type;
  ctl_state_type st_r;
  ctl_state_type st_nxt;

  logic cmd_is_nop;
  logic exit_edge;
  logic exit_from_pd;
  logic exit_from_sr;
  logic [CNT_W-1:0] nonread_load;
  logic nonread_busy;
  err_type err_set;

  assign cmd_is_nop = pin_s.cmd[3] || (pin_s.cmd == CMD_NOP);
  assign exit_edge  = !st_r.cke_prev && pin_s.cke;
  assign exit_from_pd = exit_edge && (st_r.state == ST_ACT_PD || st_r.state == ST_PRE_PD);
  assign exit_from_sr = exit_edge && (st_r.state == ST_SELF_REF);
  assign nonread_load = exit_from_sr ? CNT_W'(TXSNR_CYC) : CNT_W'(TXP_CYC);

  // non-READ hold-off after any exit
  down_counter #(.W(CNT_W)) u_nonread (
    .core_clk_i (core_clk_i),
    .sys_rst_i  (sys_rst_i),
    .load_i     (exit_from_pd || exit_from_sr),
    .value_i    (nonread_load),
    .busy_o     (nonread_busy)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;
    err_set = '0;
    st_nxt.cke_prev = pin_s.cke;
    // CKE run length since last change
    if (pin_s.cke != st_r.cke_prev) begin
      st_nxt.cke_run = 2'h1;
      if (st_r.cke_run < 2'(CKE_MIN_CYC)) err_set.cke_glitch = 1'b1; // R1
    end else if (st_r.cke_run != 2'h3) begin
      st_nxt.cke_run = st_r.cke_run + 2'h1;
    end
    // state table
    case (st_r.state)
      ST_ACTIVE: begin
        if (st_r.cke_prev && !pin_s.cke) begin
          if (cmd_is_nop) begin
            st_nxt.state = pin_s.any_bank_open ? ST_ACT_PD : ST_PRE_PD; // R6 R15 R16 R17 R18
          end else if (pin_s.cmd == CMD_REFRESH && !pin_s.any_bank_open) begin
            st_nxt.state = ST_SELF_REF; // R7
          end else if (pin_s.cmd == CMD_REFRESH) begin
            err_set.bad_sref = 1'b1; // R7
          end else begin
            err_set.illegal_cmd = 1'b1; // R10
          end
        end
      end
      ST_ACT_PD, ST_PRE_PD, ST_SELF_REF: begin
        if (exit_edge) begin
          if (cmd_is_nop) begin
            st_nxt.state = ST_ACTIVE; // R5
          end else begin
            err_set.illegal_cmd = 1'b1; // R10
          end
        end
      end
      default: st_nxt.state = ST_ACTIVE;
    endcase
    // power-down length watch, no refresh happens here
    if (st_r.state == ST_ACT_PD || st_r.state == ST_PRE_PD) begin
      if (st_r.pd_cnt != 16'hFFFF) st_nxt.pd_cnt = st_r.pd_cnt + 16'h1;
      if (st_r.pd_cnt >= st_r.pd_limit) err_set.pd_too_long = 1'b1; // R12
    end else begin
      st_nxt.pd_cnt = 16'h0;
    end
    // READ hold-off after self refresh and active power-down exits
    if (exit_from_sr) begin
      st_nxt.read_cnt = CNT_W'(TXSRD_CYC); // R8
    end else if (exit_edge && st_r.state == ST_ACT_PD) begin
      st_nxt.read_cnt = st_r.ctrl[CTRL_SLOW_EXIT_BIT] ? CNT_W'(TXARDS_CYC) // R4
                                                      : CNT_W'(TXARD_CYC); // R3
    end else if (st_r.read_cnt != '0) begin
      st_nxt.read_cnt = st_r.read_cnt - CNT_W'(1);
    end
    st_nxt.read_ok = (st_nxt.read_cnt == '0); // R3 R4
    // device-side view of buffers, DLL, termination
    st_nxt.buffers_en = (st_nxt.state == ST_ACTIVE); // R23 R13
    st_nxt.dll_frozen = (st_nxt.state == ST_PRE_PD); // R23
    st_nxt.odt_active = st_r.ctrl[CTRL_ODT_EN_BIT] && odt_s
                        && (st_nxt.state != ST_SELF_REF); // R11
    // register writes; hardware error sets win over clears
    st_nxt.err = st_r.err | err_set;
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_CTRL: st_nxt.ctrl = reg_wdata_i[1:0];
        OFS_PD_LIMIT: st_nxt.pd_limit = reg_wdata_i[15:0];
        OFS_ERRORS: st_nxt.err = st_nxt.err & ~(reg_wdata_i[3:0] & ~err_set);
        default: ;
      endcase
    end
    // register reads, data in next cycle
    st_nxt.rdata = 32'h0;
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_CTRL: st_nxt.rdata = {30'h0, st_r.ctrl};
        OFS_STATUS: st_nxt.rdata = {27'h0, nonread_busy, (st_r.read_cnt == '0),
                                    st_r.cke_prev, st_r.state};
        OFS_ERRORS: st_nxt.rdata = {28'h0, st_r.err};
        OFS_PD_LIMIT: st_nxt.rdata = {16'h0, st_r.pd_limit};
        default: st_nxt.rdata = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers, rising edge only
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
      st_r.state <= ST_ACTIVE;
      st_r.cke_run <= 2'h3;
      st_r.ctrl <= CTRL_RESET;
      st_r.pd_limit <= PD_LIMIT_RESET;
      st_r.buffers_en <= 1'b1;
      st_r.read_ok <= 1'b1;
    end else begin
      st_r <= st_nxt; // R24
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata_o  = st_r.rdata;
  assign pwr_state_o  = st_r.state;
  assign buffers_en_o = st_r.buffers_en;
  assign dll_frozen_o = st_r.dll_frozen;
  assign odt_active_o = st_r.odt_active;
  assign read_ok_o    = st_r.read_ok;
  assign cmd_ok_o     = !nonread_busy; // R2 R8
endmodule
`default_nettype wire

// ==== hdl/down_counter.sv ====
// loadable down counter reporting expiry
`default_nettype none
module down_counter
  import pwr_state_pkg::*;
#(
  parameter int W = CNT_W
) (
  input  wire logic         core_clk_i,
  input  wire logic         sys_rst_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              busy_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         busy;
  } cnt_state_type;
  cnt_state_type st_r;
  cnt_state_type st_nxt;

  initial begin
    if (W < 2) $error("down_counter: W too small");
  end

  always_comb begin
    st_nxt = st_r;
    if (load_i) begin
      st_nxt.cnt = value_i;
    end else if (st_r.cnt != '0) begin
      st_nxt.cnt = st_r.cnt - W'(1);
    end
    st_nxt.busy = (st_nxt.cnt != '0);
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign busy_o = st_r.busy;
endmodule
`default_nettype wire

// ==== hdl/sync2.sv ====
// two-flop synchroniser for pin inputs
`default_nettype none
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] d_i,
  output logic      [WIDTH-1:0] q_o
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_state_type;
  sync_state_type st_r;
  sync_state_type st_nxt;

  initial begin
    if (WIDTH < 1) $error("sync2: WIDTH must be positive");
  end

  always_comb begin
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule
`default_nettype wire

// ==== shared/pwr_state_pkg.sv ====
// package: power-state constants, command codes and carrier types
`default_nettype none
package pwr_state_pkg;
  // ---------------------------------------------------------------
  // command encoding {cs_n, ras_n, cas_n, we_n}
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_DESEL_MASK = 4'h8;
  localparam logic [3:0] CMD_NOP        = 4'h7;
  localparam logic [3:0] CMD_ACTIVE     = 4'h3;
  localparam logic [3:0] CMD_READ       = 4'h5;
  localparam logic [3:0] CMD_WRITE      = 4'h4;
  localparam logic [3:0] CMD_PRECHARGE  = 4'h2;
  localparam logic [3:0] CMD_REFRESH    = 4'h1;
  localparam logic [3:0] CMD_LOAD_MODE  = 4'h0;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [3:0] OFS_CTRL     = 4'h0;
  localparam logic [3:0] OFS_STATUS   = 4'h4;
  localparam logic [3:0] OFS_ERRORS   = 4'h8;
  localparam logic [3:0] OFS_PD_LIMIT = 4'hC;
  localparam int         CTRL_SLOW_EXIT_BIT = 0;
  localparam int         CTRL_ODT_EN_BIT    = 1;
  localparam logic [1:0] CTRL_RESET         = 2'h0;
  localparam logic [15:0] PD_LIMIT_RESET    = 16'h0C30;

  // ---------------------------------------------------------------
  // timing, in picoseconds and in cycles of the 40 MHz clock
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_PS   = 25000;
  localparam int CKE_MIN_CYC     = 3;
  localparam int TXP_PS          = 50000;
  localparam int TXARD_PS        = 50000;
  localparam int TXARDS_PS       = 150000;
  localparam int TXSNR_PS        = 200000;
  localparam int TXSRD_CYC       = 200;
  localparam int TXP_CYC    = (TXP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TXARD_CYC  = (TXARD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TXARDS_CYC = (TXARDS_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TXSNR_CYC  = (TXSNR_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int CNT_W      = 8;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_ACTIVE   = 2'b00,
    ST_ACT_PD   = 2'b01,
    ST_PRE_PD   = 2'b10,
    ST_SELF_REF = 2'b11
  } pwr_state_type;

  typedef struct packed {
    logic       cke;
    logic [3:0] cmd;
    logic       any_bank_open;
  } mem_in_type;

  typedef struct packed {
    logic illegal_cmd;
    logic cke_glitch;
    logic bad_sref;
    logic pd_too_long;
  } err_type;
endpackage
`default_nettype wire

// ==== verification/cke_power_ctrl_asserts.sv ====
// checker: port-level timing of the power-state controller
`default_nettype none
module cke_power_ctrl_asserts
  import pwr_state_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       sys_rst_i,
  input wire logic       cke_i,
  input wire logic [3:0] cmd_i,
  input wire logic       any_bank_open_i,
  input wire logic [1:0] pwr_state_o,
  input wire logic       buffers_en_o,
  input wire logic       dll_frozen_o,
  input wire logic       odt_active_o,
  input wire logic       read_ok_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ------------------------------
  // helpers and properties
  // ------------------------------
  logic cke_q;
  logic idle_c;
  logic ent;
  logic ext;
  assign idle_c = cmd_i[3] | (cmd_i == CMD_NOP);
  assign ent = cke_q & ~cke_i & (pwr_state_o == ST_ACTIVE);
  assign ext = ~cke_q & cke_i & idle_c & (pwr_state_o != ST_ACTIVE);
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cke_q <= 1'b1;
    end else begin
      cke_q <= cke_i;
    end
  end
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (sys_rst_i);
  a_pre_entry:
    assert property (ent && idle_c && !any_bank_open_i |-> ##3 pwr_state_o == ST_PRE_PD)
      else $error("pre pd entry");
  a_act_entry:
    assert property (ent && idle_c && any_bank_open_i |-> ##3 pwr_state_o == ST_ACT_PD)
      else $error("act pd entry");
  a_sref_entry:
    assert property (ent && cmd_i == CMD_REFRESH && !any_bank_open_i
      |-> ##3 pwr_state_o == ST_SELF_REF) else $error("sref entry");
  a_bad_sref:
    assert property (ent && cmd_i == CMD_REFRESH && any_bank_open_i
      |-> ##3 pwr_state_o == ST_ACTIVE) else $error("sref with open bank");
  a_pd_exit:
    assert property (ext |-> ##3 pwr_state_o == ST_ACTIVE) else $error("exit");
  a_state_cause:
    assert property ($changed(pwr_state_o) |-> $past(cke_i, 3) != $past(cke_i, 4))
      else $error("state change without cke edge");
  a_buffers_on:
    assert property (buffers_en_o == (pwr_state_o == ST_ACTIVE)) else $error("buffers");
  a_dll_frozen:
    assert property (dll_frozen_o == (pwr_state_o == ST_PRE_PD)) else $error("dll");
  a_odt_sref:
    assert property (pwr_state_o == ST_SELF_REF && $stable(pwr_state_o) |-> !odt_active_o)
      else $error("odt in sref");
  a_sref_read:
    assert property ($past(pwr_state_o) == ST_SELF_REF && pwr_state_o == ST_ACTIVE
      |-> ##1 !read_ok_o [*8] ##[180:200] read_ok_o) else $error("sref read holdoff");
  c_pre: cover property (pwr_state_o == ST_PRE_PD);
  c_act: cover property (pwr_state_o == ST_ACT_PD);
  c_sref: cover property (pwr_state_o == ST_SELF_REF);
endmodule
bind cke_power_ctrl cke_power_ctrl_asserts chk_u (.core_clk_i(core_clk_i),
  .sys_rst_i(sys_rst_i), .cke_i(cke_i), .cmd_i(cmd_i), .any_bank_open_i(any_bank_open_i),
  .pwr_state_o(pwr_state_o), .buffers_en_o(buffers_en_o), .dll_frozen_o(dll_frozen_o),
  .odt_active_o(odt_active_o), .read_ok_o(read_ok_o));
`default_nettype wire

// ==== verification/ddr_ctl_model.sv ====
// partner: memory controller driving cke, command, bank and odt pins
`default_nettype none
module ddr_ctl_model
  import pwr_state_pkg::*;
(
  input  wire logic  core_clk_i,
  output logic       cke_o,
  output logic [3:0] cmd_o,
  output logic       bank_o,
  output logic       odt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cke_o = 1'b1;
    cmd_o = CMD_NOP;
    bank_o = 1'b0;
    odt_o = 1'b0;
  end
  // one command beside the new cke level, then nop or deselect filler
  task automatic send(input logic c, input logic [3:0] k);
    @(posedge core_clk_i);
    cke_o <= c;
    cmd_o <= k;
    if (k == CMD_ACTIVE) bank_o <= 1'b1;
    if (k == CMD_PRECHARGE) bank_o <= 1'b0;
    @(posedge core_clk_i);
    cmd_o <= c ? CMD_NOP : 4'hF;
  endtask
  // keep the cke level, never shorter than the minimum hold
  task automatic idle(input int n);
    repeat (n < CKE_MIN_CYC ? CKE_MIN_CYC : n) @(posedge core_clk_i);
  endtask
  task automatic set_odt(input logic v);
    @(posedge core_clk_i);
    odt_o <= v;
  endtask
endmodule
`default_nettype wire

// ==== verification/tb_cke_power_ctrl.sv ====
// testbench: power-state walks, register access and refused cke edges
`default_nettype none
module tb_cke_power_ctrl;
  timeunit 1ns;
  timeprecision 1ps;
  import pwr_state_pkg::*;
  logic        clk, rst, cke, bank, odt, wr, rd, rok, cok, odt_act;
  logic [1:0]  st;
  logic [3:0]  cmd, addr;
  logic [31:0] wdata, rdata, seed;
  int          failures = 0;
  int          num_checks = 0;
  int          cyc = 0;
  ddr_ctl_model ctl_u (.core_clk_i(clk), .cke_o(cke), .cmd_o(cmd), .bank_o(bank), .odt_o(odt));
  cke_power_ctrl dut_u (.core_clk_i(clk), .sys_rst_i(rst), .cke_i(cke), .cmd_i(cmd),
    .any_bank_open_i(bank), .odt_i(odt), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .pwr_state_o(st), .buffers_en_o(),
    .dll_frozen_o(), .odt_active_o(odt_act), .read_ok_o(rok), .cmd_ok_o(cok));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      failures = failures + 1;
      report_and_stop();
    end
  end
  // ------------------------------
  // helpers
  // ------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic pwr_state_type exp_state(input int kind);
    return kind == 0 ? ST_PRE_PD : kind == 1 ? ST_ACT_PD : ST_SELF_REF;
  endfunction
  task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("wrong value %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [3:0] a, input logic [31:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(n, e, rdata);
  endtask
  // enter a power state, hold, leave, then watch both hold-offs
  task automatic walk(input int kind, input int hold, input logic [2:0] r);
    int rl;
    int cl;
    rl = kind == 2 ? TXSRD_CYC : kind == 1 ? (r[0] ? TXARDS_CYC : TXARD_CYC) : 0;
    cl = kind == 2 ? TXSNR_CYC : TXP_CYC;
    reg_wr(OFS_CTRL, {30'h0, r[1], r[0]});
    ctl_u.set_odt(r[2]);
    ctl_u.idle(4);
    #1 check("odt", 32'(r[1] & r[2]), 32'(odt_act));
    ctl_u.send(1'b1, kind == 1 ? CMD_ACTIVE : CMD_PRECHARGE);
    ctl_u.send(1'b0, kind == 2 ? CMD_REFRESH : CMD_NOP);
    repeat (2) @(posedge clk);
    #1 check("state", 32'(exp_state(kind)), 32'(st));
    ctl_u.idle(hold);
    ctl_u.send(1'b1, CMD_NOP);
    repeat (2) @(posedge clk);
    #1 check("state", 32'(ST_ACTIVE), 32'(st));
    for (int o = 0; o <= rl + 1 || o <= cl + 1; o++) begin
      if (o == 0 || o == rl - 1 || o == rl) check("read_ok", 32'(o >= rl), 32'(rok));
      if (o == 0 || o == cl - 1 || o == cl) check("cmd_ok", 32'(o >= cl), 32'(cok));
      @(posedge clk);
      #1;
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ------------------------------
  // main sequence
  // ------------------------------
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 4'h0;
    wdata = 32'h0;
    seed = 32'h43780846;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    reg_rd(OFS_CTRL, 32'(CTRL_RESET), "ctrl");
    reg_rd(OFS_PD_LIMIT, 32'(PD_LIMIT_RESET), "pd_limit");
    reg_rd(4'h2, 32'h0, "unmapped");
    ctl_u.send(1'b0, CMD_ACTIVE);
    ctl_u.idle(3);
    #1 check("state", 32'(ST_ACTIVE), 32'(st));
    reg_rd(OFS_ERRORS, 32'h8, "errors");
    ctl_u.send(1'b1, CMD_NOP);
    ctl_u.idle(3);
    reg_wr(OFS_ERRORS, 32'hF);
    ctl_u.send(1'b0, CMD_REFRESH);
    ctl_u.idle(3);
    reg_rd(OFS_ERRORS, 32'h2, "errors");
    ctl_u.send(1'b1, CMD_NOP);
    ctl_u.idle(3);
    reg_wr(OFS_ERRORS, 32'hF);
    ctl_u.send(1'b0, CMD_NOP);
    ctl_u.send(1'b1, CMD_NOP);
    ctl_u.idle(3);
    reg_rd(OFS_ERRORS, 32'h4, "errors");
    reg_wr(OFS_ERRORS, 32'hF);
    reg_wr(OFS_PD_LIMIT, 32'h10);
    walk(0, 40, 3'h0);
    reg_rd(OFS_ERRORS, 32'h1, "errors");
    walk(1, 3, 3'h1);
    walk(1, 3, 3'h6);
    walk(2, 3, 3'h6);
    repeat (12) begin
      seed = lfsr(seed);
      walk(int'(seed[1:0]) % 3, 3 + int'(seed[7:4]), seed[10:8]);
    end
    report_and_stop();
  end
endmodule
`default_nettype wire
